// ===== hdl/ssx_sync_serial.v
// Clocked synchronous serial interface with buffers, flags and error handling
//
// Functional notes
// - Receive overrun freezes shift register and buffer
// - External clock: shift done while full flags overrun
// - After overrun, second buffer read returns shift register
// - Clearing overrun flag also clears receive full
// - Start cleared: stop after current eight clocks
// - Force stop halts and clears all but mode, order and clock select
// - No interrupts while overrun error stands
// - Mode value binary 10 selects full duplex
// - Tx write clears txf, rx read clears rxf
// - Active flag set on next falling edge
// - Out on falling, in on rising, same order
// - Shift flag high across the byte's eight clocks
// - txf on rise after load; byte done sets rxf, interrupt
// - Internal clock starts within one serial period
// - External: first falling edge loads shift register
// - Internal clock parks high until buffers serviced
// - Underrun flags at shift start, interrupt at byte end
// - Underrun holds data out high until force stop
// - Unread buffer at next shift end flags overrun
// - Start cleared ends after byte, data out high
// - Order bit 0 MSB first, 1 LSB first
`timescale 1ns/1ps
`include "ssx_regs.vh"

module ssx_sync_serial (
  input  wire       i_core_clk,
  input  wire       i_nrst,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_sck,
  output reg        o_sck,
  output reg        o_sck_oe_n,
  input  wire       i_si,
  output reg        o_so,
  output reg        o_serial_int
);

  localparam integer HALF_CYC = `SSX_SCK_HALF_CYC;
  localparam [7:0]   HALF_M1  = HALF_CYC[7:0] - 8'h01;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire sck_sync;
  wire si_sync;
  reg  sck_dly_q;

  // Both pins idle high, so reset values give no false edge
  ssx_sync2 #(
    .RST_VAL(1'b1)
  ) sck_sync_u (
    .i_core_clk(i_core_clk),
    .i_nrst    (i_nrst),
    .i_d       (i_sck),
    .o_q       (sck_sync)
  );

  ssx_sync2 #(
    .RST_VAL(1'b1)
  ) si_sync_u (
    .i_core_clk(i_core_clk),
    .i_nrst    (i_nrst),
    .i_d       (i_si),
    .o_q       (si_sync)
  );

  // Third stage only delays the clean level for edge detection
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sck_dly_q <= 1'b1;
    end else begin
      sck_dly_q <= sck_sync;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg       start_q;
  reg [1:0] mode_q;
  reg       lsb_q;
  reg       ext_q;
  reg       act_q;
  reg       sef_q;
  reg       txf_q;
  reg       rxf_q;
  reg       transmit_underrun_error_q;
  reg       receive_overrun_error_q;
  reg       err_rd_q;
  reg       tx_pend_q;
  reg       loaded_q;
  reg [7:0] txbuf_q;
  reg [7:0] rxbuf_q;
  reg [7:0] sh_q;
  reg [2:0] cnt_q;
  reg [7:0] div_q;

  wire need_tx = (mode_q != `SSX_MODE_RX);
  wire need_rx = (mode_q != `SSX_MODE_TX);

  // Internal clock may only begin a byte once the buffers the mode uses are serviced
  wire ready = (!need_tx || tx_pend_q) && (!need_rx || !rxf_q) && !receive_overrun_error_q && !transmit_underrun_error_q;

  wire run_clk = !ext_q && (sef_q || (start_q && ready));
  wire tick    = run_clk && (div_q == HALF_M1);

  wire fall_ev = ext_q ? (sck_dly_q && !sck_sync) : (tick && o_sck);
  wire rise_ev = ext_q ? (!sck_dly_q && sck_sync) : (tick && !o_sck);

  wire wr_ctrl  = i_wr && (i_addr == `SSX_OFS_CTRL);
  wire wr_stat  = i_wr && (i_addr == `SSX_OFS_STATUS);
  wire wr_tx    = i_wr && (i_addr == `SSX_OFS_TXBUF);
  wire rd_rx    = i_rd && (i_addr == `SSX_OFS_RXBUF);
  wire fstop    = wr_ctrl && i_wdata[`SSX_CTRL_FSTOP];

  wire       byte_go  = fall_ev && !sef_q && start_q;
  wire       byte_end = rise_ev && sef_q && (cnt_q == 3'h7);
  wire [7:0] sh_in    = lsb_q ? {si_sync, sh_q[7:1]} : {sh_q[6:0], si_sync};
  wire       out_bit  = lsb_q ? sh_q[0] : sh_q[7];
  wire       first_b  = lsb_q ? txbuf_q[0] : txbuf_q[7];

  wire [7:0] status = {2'h0, receive_overrun_error_q, transmit_underrun_error_q, rxf_q, txf_q, sef_q, act_q};
  wire [7:0] ctrl   = {2'h0, ext_q, lsb_q, mode_q, 1'b0, start_q};

  // ----------------------------------------------------------------------
  // Internal serial clock generator
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (!i_nrst || fstop) begin
      div_q      <= 8'h00;
      o_sck      <= 1'b1;
      o_sck_oe_n <= 1'b1;
    end else begin
      o_sck_oe_n <= ext_q;
      // Divider rests at zero, so every start waits a full half period
      // counting begins on start, first edge within one period
      if (!run_clk || tick) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
      if (tick) begin
        o_sck <= !o_sck;
      end else if (ext_q) begin
        o_sck <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads: data valid in the cycle after the strobe only
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        `SSX_OFS_CTRL:   o_rdata <= ctrl;
        `SSX_OFS_STATUS: o_rdata <= status;
        `SSX_OFS_TXBUF:  o_rdata <= txbuf_q;
        // first read gives last good byte, next gives shift register
        `SSX_OFS_RXBUF:  o_rdata <= (receive_overrun_error_q && err_rd_q) ? sh_q : rxbuf_q;
        default:         o_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transfer engine and flags (hardware sets are placed after clears)
  // ----------------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (!i_nrst || fstop) begin
      start_q      <= 1'b0;
      act_q        <= 1'b0;
      sef_q        <= 1'b0;
      txf_q        <= 1'b0;
      rxf_q        <= 1'b0;
      transmit_underrun_error_q      <= 1'b0;
      receive_overrun_error_q      <= 1'b0;
      err_rd_q     <= 1'b0;
      tx_pend_q    <= 1'b0;
      loaded_q     <= 1'b0;
      txbuf_q      <= `SSX_RST_BYTE;
      rxbuf_q      <= `SSX_RST_BYTE;
      sh_q         <= `SSX_RST_BYTE;
      cnt_q        <= 3'h0;
      o_so         <= 1'b1;
      o_serial_int <= 1'b0;
      if (!i_nrst) begin
        mode_q <= `SSX_MODE_TX;
        lsb_q  <= 1'b0;
        ext_q  <= 1'b0;
      end else begin
        // Force stop keeps the mode, order and clock select just written
        mode_q <= i_wdata[`SSX_CTRL_MODE_HI:`SSX_CTRL_MODE_LO];
        lsb_q  <= i_wdata[`SSX_CTRL_ORDER];
        ext_q  <= i_wdata[`SSX_CTRL_EXTCLK];
      end
    end else begin
      o_serial_int <= 1'b0;

      // ---- Software side --------------------------------------------
      if (wr_ctrl) begin
        start_q <= i_wdata[`SSX_CTRL_START];
        // mode field, 2'h2 is full duplex
        mode_q  <= i_wdata[`SSX_CTRL_MODE_HI:`SSX_CTRL_MODE_LO];
        lsb_q   <= i_wdata[`SSX_CTRL_ORDER];
        ext_q   <= i_wdata[`SSX_CTRL_EXTCLK];
      end
      if (wr_tx) begin
        txbuf_q   <= i_wdata;
        tx_pend_q <= 1'b1;
        txf_q     <= 1'b0;
      end
      if (rd_rx) begin
        rxf_q <= 1'b0;
        if (receive_overrun_error_q) begin
          err_rd_q <= 1'b1;
        end
      end
      // overrun clear takes rxf with it
      if (wr_stat && i_wdata[`SSX_ST_RECEIVE_OVERRUN_ERROR]) begin
        receive_overrun_error_q  <= 1'b0;
        rxf_q    <= 1'b0;
        err_rd_q <= 1'b0;
      end

      // idle with start cleared, nothing left to finish
      if (!start_q && !sef_q) begin
        act_q <= 1'b0;
        o_so  <= 1'b1;
      end

      // ---- Falling edge: start of byte or next output bit -----------
      if (byte_go) begin
        // active on falling edge / shift flag from first fall
        act_q <= 1'b1;
        sef_q <= 1'b1;
        cnt_q <= 3'h0;
        if (need_tx && tx_pend_q) begin
          if (!receive_overrun_error_q) begin
            sh_q <= txbuf_q;
          end
          // A write on the load edge stays pending for the next byte
          if (!wr_tx) begin
            tx_pend_q <= 1'b0;
          end
          loaded_q  <= 1'b1;
          o_so      <= transmit_underrun_error_q ? 1'b1 : first_b;
        end else begin
          loaded_q <= 1'b0;
          o_so     <= 1'b1;
          // underrun flagged at once when shifting starts
          if (need_tx) begin
            transmit_underrun_error_q <= 1'b1;
          end
        end
      end else if (fall_ev && sef_q) begin
        // data out on falling edge / held high on underrun
        o_so <= (transmit_underrun_error_q || !need_tx) ? 1'b1 : out_bit;
      end

      // ---- Rising edge: sample input --------------------------------
      if (rise_ev && sef_q) begin
        cnt_q <= cnt_q + 3'h1;
        // frozen while overrun stands / sample on rising edge
        if (!receive_overrun_error_q) begin
          sh_q <= sh_in;
        end
        // txf set on rise after load
        if (cnt_q == 3'h0 && loaded_q) begin
          txf_q <= 1'b1;
        end
      end

      // ---- End of byte ----------------------------------------------
      if (byte_end) begin
        sef_q <= 1'b0;
        // stop after current byte / data out parks high
        if (!start_q || (wr_ctrl && !i_wdata[`SSX_CTRL_START])) begin
          act_q <= 1'b0;
          o_so  <= 1'b1;
        end
        if (need_rx && !receive_overrun_error_q) begin
          // overrun when buffer unread / flagged at shift end
          if (rxf_q && !rd_rx) begin
            receive_overrun_error_q <= 1'b1;
          end else begin
            rxbuf_q <= sh_in;
            rxf_q   <= 1'b1;
          end
        end
        // The overrun flag is still old here, so the byte that sets it interrupts
        // silent once overrun stands / interrupt at byte end
        if (!receive_overrun_error_q) begin
          o_serial_int <= 1'b1;
        end
      end
    end
  end

endmodule

// ----------------------------------------------------------------------
// Two-stage synchroniser for one pin
// ----------------------------------------------------------------------
module ssx_sync2 #(
  parameter [0:0] RST_VAL = 1'b1
) (
  input  wire i_core_clk,
  input  wire i_nrst,
  input  wire i_d,
  output reg  o_q
);

  // Only the second stage may be read; the first can be metastable
  reg meta_q;

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta_q <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule

// ===== shared/ssx_regs.vh
// Register map, field positions and timing constants of the sync serial block
`ifndef SSX_REGS_VH
`define SSX_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SSX_OFS_CTRL    8'h00
`define SSX_OFS_STATUS  8'h04
`define SSX_OFS_RXBUF   8'h08
`define SSX_OFS_TXBUF   8'h0C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SSX_CTRL_START   0
`define SSX_CTRL_FSTOP   1
`define SSX_CTRL_MODE_LO 2
`define SSX_CTRL_MODE_HI 3
`define SSX_CTRL_ORDER   4
`define SSX_CTRL_EXTCLK  5

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SSX_ST_ACTIVE  0
`define SSX_ST_SHIFT   1
`define SSX_ST_TXF     2
`define SSX_ST_RXF     3
`define SSX_ST_TRANSMIT_UNDERRUN_ERROR   4
`define SSX_ST_RECEIVE_OVERRUN_ERROR   5

// ----------------------------------------------------------------------
// Transfer modes and reset values
// ----------------------------------------------------------------------
`define SSX_MODE_TX    2'h0
`define SSX_MODE_RX    2'h1
`define SSX_MODE_DUP   2'h2
`define SSX_RST_BYTE   8'h00

// ----------------------------------------------------------------------
// Timing: internal serial clock half period
// ----------------------------------------------------------------------
`define SSX_CLK_NS       40
`define SSX_SCK_HALF_NS  160
`define SSX_SCK_HALF_CYC ((`SSX_SCK_HALF_NS + `SSX_CLK_NS - 1) / `SSX_CLK_NS)

`endif

// ===== test/ssx_serial_peer.sv
// Far-end serial peer: makes the external clock, sends and takes bytes
`timescale 1ns/1ps
module ssx_serial_peer (
  input  wire        i_line_sck,
  input  wire        i_so,
  input  wire        i_lsb,
  input  wire  [7:0] i_tx,
  output logic       o_sck,
  output logic       o_si,
  output logic [7:0] o_rx
);
  int cnt;
  initial begin
    o_sck = 1'b1;
    o_si  = 1'b1;
    o_rx  = 8'h00;
    cnt   = 0;
  end
  // out on falling edge, same order
  always @(negedge i_line_sck) begin
    o_si = i_lsb ? i_tx[cnt] : i_tx[7 - cnt];
  end
  // sample late, the device moves data out a few cycles after the edge
  always @(posedge i_line_sck) begin
    #100 o_rx = i_lsb ? {i_so, o_rx[7:1]} : {o_rx[6:0], i_so};
    cnt = cnt + 1;
    if (cnt == 8) begin
      cnt = 0;
      #60 o_si = ~o_si;
    end
  end
  task automatic clocks(input int n);
    repeat (n) begin
      #160 o_sck = 1'b0;
      #160 o_sck = 1'b1;
    end
  endtask
endmodule

// ===== test/ssx_sync_serial_bench.sv
// Self-checking bench for the sync serial block
`timescale 1ns/1ps
module ssx_sync_serial_bench;
  logic       clk, nrst, wr, rd, lsb, o_sck, oe_n, so, sint, psck, si;
  logic [7:0] addr, wdata, rdata, ptx, prx, got;
  int         fail_count, tests_run, cycles, ints;
  wire        line_sck = (oe_n === 1'b0) ? o_sck : psck;

  ssx_sync_serial dut_u (
    .i_core_clk  (clk),
    .i_nrst      (nrst),
    .i_addr      (addr),
    .i_wdata     (wdata),
    .i_wr        (wr),
    .i_rd        (rd),
    .o_rdata     (rdata),
    .i_sck       (line_sck),
    .o_sck       (o_sck),
    .o_sck_oe_n  (oe_n),
    .i_si        (si),
    .o_so        (so),
    .o_serial_int(sint)
  );
  ssx_serial_peer peer_u (
    .i_line_sck(line_sck),
    .i_so      (so),
    .i_lsb     (lsb),
    .i_tx      (ptx),
    .o_sck     (psck),
    .o_si      (si),
    .o_rx      (prx)
  );

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (sint === 1'b1) ints++;
    if (cycles == 30000) begin
      fail_count++;
      test_done;
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wait_int(input int n0);
    for (int j = 0; j < 600 && ints == n0; j++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    for (int k = 0; k < 5; k++) begin
      rd_reg(8'(k * 4));
      check(got, 8'h00);
    end
    check({6'h00, so, o_sck}, 8'h03);
    $display("reset test done");
  endtask
  task automatic t_dup(input logic l);
    int k;
    lsb = l;
    ptx = 8'h34;
    wr_reg(8'h0C, 8'hA1);
    wr_reg(8'h00, {3'b000, l, 4'b1001});
    wait_int(ints);
    check(prx, 8'hA1);
    rd_reg(8'h04);
    check(got & 8'h0C, 8'h0C);
    rd_reg(8'h08);
    check(got, 8'h34);
    rd_reg(8'h04);
    check(got & 8'h08, 8'h00);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      k += (o_sck !== 1'b1);
    end
    check(8'(k), 8'h00);
    ptx = 8'hC6;
    wr_reg(8'h0C, 8'h5C);
    wait_int(ints);
    check(prx, 8'h5C);
    rd_reg(8'h08);
    check(got, 8'hC6);
    wr_reg(8'h00, {3'b000, l, 4'b1010});
    rd_reg(8'h04);
    check(got, 8'h00);
    rd_reg(8'h08);
    check(got, 8'h00);
    $display("duplex test done");
  endtask
  task automatic t_simplex;
    lsb = 1'b0;
    ptx = 8'h6D;
    wr_reg(8'h00, 8'h05);
    wait_int(ints);
    check(prx, 8'hFF);
    wr_reg(8'h00, 8'h04);
    rd_reg(8'h04);
    check(got, 8'h08);
    rd_reg(8'h08);
    check(got, 8'h6D);
    ptx = 8'h00;
    wr_reg(8'h0C, 8'hB4);
    wr_reg(8'h00, 8'h01);
    wait_int(ints);
    check(prx, 8'hB4);
    rd_reg(8'h04);
    check(got, 8'h05);
    rd_reg(8'h08);
    check(got, 8'h6D);
    wr_reg(8'h00, 8'h02);
    $display("simplex test done");
  endtask
  task automatic t_under;
    int k, n;
    n = ints;
    lsb = 1'b0;
    ptx = 8'h5A;
    wr_reg(8'h00, 8'h29);
    rd_reg(8'h04);
    check(got, 8'h00);
    k = 0;
    fork
      peer_u.clocks(8);
      repeat (70) begin
        @(posedge clk);
        k += (so !== 1'b1);
      end
    join
    wait_int(n);
    check(8'(k), 8'h00);
    check(8'(ints - n), 8'h01);
    rd_reg(8'h04);
    check(got & 8'h10, 8'h10);
    rd_reg(8'h08);
    check(got, 8'h5A);
    wr_reg(8'h00, 8'h2A);
    rd_reg(8'h04);
    check(got, 8'h00);
    $display("underrun test done");
  endtask
  task automatic t_over;
    int n;
    n = ints;
    lsb = 1'b1;
    ptx = 8'h81;
    wr_reg(8'h0C, 8'h11);
    wr_reg(8'h00, 8'h39);
    peer_u.clocks(8);
    wait_int(n);
    wr_reg(8'h0C, 8'h22);
    ptx = 8'h42;
    peer_u.clocks(8);
    wait_int(n + 1);
    rd_reg(8'h04);
    check(got & 8'h20, 8'h20);
    check(8'(ints - n), 8'h02);
    wr_reg(8'h0C, 8'h33);
    ptx = 8'hE7;
    peer_u.clocks(8);
    repeat (8) @(posedge clk);
    check(8'(ints - n), 8'h02);
    wr_reg(8'h00, 8'h38);
    peer_u.clocks(8);
    repeat (8) @(posedge clk);
    rd_reg(8'h04);
    check(got & 8'h01, 8'h00);
    rd_reg(8'h08);
    check(got, 8'h81);
    rd_reg(8'h08);
    check(got, 8'h42);
    wr_reg(8'h04, 8'h20);
    rd_reg(8'h04);
    check(got & 8'h28, 8'h00);
    $display("overrun test done");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    lsb = 1'b0;
    ptx = 8'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // The line clock leaves X at time zero, which the peer may count as an edge
    peer_u.cnt = 0;
    t_reset;
    t_dup(1'b0);
    t_dup(1'b1);
    t_simplex;
    t_under;
    t_over;
    test_done;
  end
endmodule

// ===== test/ssx_sync_serial_checker.sv
// Port assertions for the sync serial block
`timescale 1ns/1ps
module ssx_port_checker (
  input wire       i_core_clk,
  input wire       i_nrst,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       o_sck,
  input wire       o_sck_oe_n,
  input wire       o_so,
  input wire       o_serial_int
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  // Internal serial clock half period is 4 core cycles
  sequence s_low_half;
    !o_sck [*4] ##1 o_sck;
  endsequence
  sequence s_quiet;
    !o_serial_int [*8];
  endsequence
  chk_reset_idle:
    assert property (disable iff (1'b0) !i_nrst |=> o_sck && o_so && o_sck_oe_n
      && !o_serial_int && o_rdata == 8'h00) else $error("outputs not idle in reset");
  chk_rdata_gap:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
  chk_sck_low:
    assert property ($fell(o_sck) |-> s_low_half) else $error("low phase length wrong");
  chk_sck_high:
    assert property ($rose(o_sck) |-> o_sck [*4]) else $error("high phase too short");
  chk_sck_internal:
    assert property ($fell(o_sck) |-> !o_sck_oe_n) else $error("clock moved in ext mode");
  chk_ext_idle:
    assert property (o_sck_oe_n |-> o_sck) else $error("undriven clock not high");
  chk_int_gap:
    assert property (o_serial_int |=> s_quiet) else $error("interrupt too soon");
  chk_int_parked:
    assert property (o_serial_int && !o_sck_oe_n |-> o_sck) else $error("int with clock low");
endmodule

bind ssx_sync_serial ssx_port_checker chk_u (
  .i_core_clk  (i_core_clk),
  .i_nrst      (i_nrst),
  .i_rd        (i_rd),
  .o_rdata     (o_rdata),
  .o_sck       (o_sck),
  .o_sck_oe_n  (o_sck_oe_n),
  .o_so        (o_so),
  .o_serial_int(o_serial_int)
);
